// file: hdl/serial_mgmt_port.sv
// Serial management port: two-wire slave with sub-address pointer and auto-increment on reads.
// Assumes scl and sda_in are synchronous to clk_sys and slow against it.
`timescale 1ns/10ps
`default_nettype none

module serial_mgmt_port #(
	parameter logic [6:0] DEV_ADDR = 7'h20
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output sysctl_pkg::reg_write_type reg_write
);
	import sysctl_pkg::*;

	serial_state_type state_q; // Protocol state
	logic scl_prev_q; // Previous scl for edges
	logic sda_prev_q; // Previous sda for start and stop
	logic [3:0] bit_cnt_q; // Bits taken in this byte
	logic [7:0] shift_q; // Receive shifter
	logic [7:0] tx_q; // Transmit shifter
	logic [7:0] ptr_q; // Sub-address pointer
	logic read_q; // Direction of this transfer
	logic nack_q; // Master refused the last byte
	logic scl_rise, scl_fall, start_seen, stop_seen;

	assign scl_rise = scl && !scl_prev_q;
	assign scl_fall = !scl && scl_prev_q;
	assign start_seen = scl && scl_prev_q && sda_prev_q && !sda_in;
	assign stop_seen = scl && scl_prev_q && !sda_prev_q && sda_in;
	assign rd_addr = ptr_q;
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Line history
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (clk_en) begin
			scl_prev_q <= scl;
			sda_prev_q <= sda_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protocol engine; start and stop override any bit in flight
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= SP_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			read_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (clk_en) begin
			if (start_seen) begin
				state_q <= SP_DEVADDR;
				bit_cnt_q <= 4'h0;
			end else if (stop_seen) begin
				state_q <= SP_IDLE;
			end else if (scl_rise) begin
				// Receivers sample on the rising edge
				if (state_q == SP_DEVADDR || state_q == SP_SUBADDR || state_q == SP_WRDATA) begin
					shift_q <= {shift_q[6:0], sda_in};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				if (state_q == SP_ACK_RD) begin
					nack_q <= sda_in;
				end
			end else if (scl_fall) begin
				case (state_q)
					SP_DEVADDR: begin
						if (bit_cnt_q == 4'h8) begin
							// Foreign address: stay off the line until next start
							state_q <= (shift_q[7:1] == DEV_ADDR) ? SP_ACK_ADDR : SP_IDLE;
							read_q <= shift_q[0];
						end
					end
					SP_ACK_ADDR: begin
						bit_cnt_q <= 4'h0;
						if (read_q) begin
							state_q <= SP_RDDATA;
							tx_q <= rd_data;
						end else begin
							state_q <= SP_SUBADDR;
						end
					end
					SP_SUBADDR: begin
						if (bit_cnt_q == 4'h8) begin
							state_q <= SP_ACK_SUB;
							ptr_q <= shift_q;
						end
					end
					SP_ACK_SUB, SP_ACK_WR: begin
						state_q <= SP_WRDATA;
						bit_cnt_q <= 4'h0;
					end
					SP_WRDATA: begin
						if (bit_cnt_q == 4'h8) begin
							state_q <= SP_ACK_WR;
						end
					end
					SP_RDDATA: begin
						if (bit_cnt_q == 4'h7) begin
							state_q <= SP_ACK_RD;
							ptr_q <= ptr_q + 8'h01;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
					SP_ACK_RD: begin
						bit_cnt_q <= 4'h0;
						if (nack_q) begin
							state_q <= SP_IDLE;
						end else begin
							state_q <= SP_RDDATA;
							tx_q <= rd_data;
						end
					end
					default: begin
						state_q <= SP_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write strobe: one cycle, at the fall that closes a data byte; the pointer holds
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_write <= '0;
		end else if (clk_en) begin
			reg_write.wr <= 1'b0;
			if (scl_fall && !start_seen && !stop_seen && state_q == SP_WRDATA
				&& bit_cnt_q == 4'h8) begin
				reg_write.wr <= 1'b1;
				reg_write.addr <= ptr_q;
				reg_write.wdata <= shift_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Open-drain drive: enable low pulls sda low
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sda_oe_n <= 1'b1;
		end else if (clk_en) begin
			case (state_q)
				SP_ACK_ADDR, SP_ACK_SUB, SP_ACK_WR: sda_oe_n <= 1'b0;
				SP_RDDATA: sda_oe_n <= tx_q[7];
				default: sda_oe_n <= 1'b1;
			endcase
		end
	end

endmodule

`default_nettype wire

// file: hdl/sysctl_defines.svh
// Sub-addresses, bit positions, reset values and colour levels of the system control bank.
// Assumes it is included by bare name; it holds definitions only.
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// Register sub-addresses
`define SUB_DEVICE_VERSION 8'h02
`define SUB_CHIP_CONTROL 8'h03
`define SUB_VSYNC_DELAY_LOW 8'h7c
`define SUB_PIXEL_COUNT_HIGH 8'h7d
`define SUB_PIXEL_COUNT_LOW 8'h7e
`define SUB_LINE_COUNT_HIGH_FORMAT 8'h7f
`define SUB_LINE_COUNT_LOW 8'h80
`define SUB_TIMING_POLARITY 8'h82
`define SUB_COPY_HEADER 8'h83
`define SUB_COPY_PAYLOAD_HIGH 8'h84
`define SUB_COPY_PAYLOAD_LOW 8'h85
`define SUB_PPL_LOW 8'h86
`define SUB_PPL_HIGH 8'h87
`define SUB_LPF_LOW 8'h88
`define SUB_LPF_HIGH 8'h89

// Chip control bit positions
`define CTL_DIRECT_CLOCK 7
`define CTL_DLL_BYPASS 6
`define CTL_COLOUR_BARS 5
`define CTL_LOW_RANGE 4
`define CTL_DAC_POWER_DOWN 3
`define CTL_CHIP_POWER_DOWN 2
`define CTL_MASTER_SELECT 1
`define CTL_SOFT_RESET_N 0

// Timing polarity control bit positions
`define POL_EMBEDDED_TIMING 5
`define POL_VSYNC_OUT 4
`define POL_HSYNC_OUT 3

// Reset values and read masks
`define RST_CHIP_CONTROL 8'h01
`define RST_ZERO_BYTE 8'h00
`define MASK_COPY_HEADER 8'h7f
`define MASK_COPY_PAYLOAD_HIGH 8'h3f

// Colour bar levels
`define BAR_LEVEL_HIGH 10'h3ff
`define BAR_LEVEL_LOW 10'h000

`endif

// file: hdl/sysctl_pkg.sv
// Types shared by the system control bank and its serial port.
// Assumes the defines header is available for the constants.
package sysctl_pkg;

	// Clock scheme steering toward the clock generator
	typedef struct packed {
		logic dll_enable;
		logic pin_is_2x_clock;
		logic direct_mode;
		logic dll_low_range;
		logic interp_2x_allowed;
		logic half_rate_enable;
	} clock_cfg_type;

	// Measurements reported by the second timing generator
	typedef struct packed {
		logic [15:0] pixel_count;
		logic input_format;
		logic [10:0] line_count;
		logic [15:0] pixels_per_line;
		logic [15:0] lines_per_frame;
	} measure_type;

	// One pixel, three converter channels
	typedef struct packed {
		logic [9:0] ch_r;
		logic [9:0] ch_g;
		logic [9:0] ch_b;
	} pixel_type;

	// One register write from the serial port
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_write_type;

	// Serial port states, one-hot
	typedef enum logic [8:0] {
		SP_IDLE = 9'b0_0000_0001,
		SP_DEVADDR = 9'b0_0000_0010,
		SP_ACK_ADDR = 9'b0_0000_0100,
		SP_SUBADDR = 9'b0_0000_1000,
		SP_ACK_SUB = 9'b0_0001_0000,
		SP_WRDATA = 9'b0_0010_0000,
		SP_ACK_WR = 9'b0_0100_0000,
		SP_RDDATA = 9'b0_1000_0000,
		SP_ACK_RD = 9'b1_0000_0000
	} serial_state_type;

endpackage

// file: hdl/system_control_regs.sv
// System control bank: version readback, chip control, timing and copy-management storage,
// clock scheme steering, power-down, soft reset, master timing and colour bars.
// Assumes clk_sys is the pixel clock and all pins are synchronous to it.
`include "sysctl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module system_control_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h20, // Serial slave address
	parameter logic [7:0] VERSION_CODE = 8'h5a, // Arbitrary value
	parameter int unsigned H_ACTIVE = 640, // Active pixels per line, master timing
	parameter int unsigned H_SYNC_START = 656, // First hsync pixel
	parameter int unsigned H_SYNC_END = 752, // First pixel after hsync
	parameter int unsigned H_TOTAL = 800, // Pixels per line
	parameter int unsigned V_ACTIVE = 480, // Active lines per frame
	parameter int unsigned V_SYNC_START = 490, // First vsync line
	parameter int unsigned V_SYNC_END = 492, // First line after vsync
	parameter int unsigned V_TOTAL = 525 // Lines per frame
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic pc_graphics_mode,
	input wire logic half_rate_request,
	input wire sysctl_pkg::measure_type measure,
	input wire sysctl_pkg::pixel_type video_in,
	output sysctl_pkg::pixel_type video_out,
	output sysctl_pkg::clock_cfg_type clock_cfg,
	output logic dac_power_down,
	output logic logic_power_down,
	output logic func_reset_n,
	output logic master_active,
	output logic sync_from_embedded,
	output logic hsync_out,
	output logic vsync_out,
	output logic data_request
);
	import sysctl_pkg::*;

	localparam int unsigned BAR_WIDTH = H_ACTIVE / 8; // Pixels per colour bar

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	reg_write_type reg_write; // Write strobe from the serial port
	logic [7:0] rd_addr; // Sub-address the serial port reads
	logic [7:0] rd_data; // Byte returned for rd_addr
	logic [7:0] chip_control_q; // Chip control byte
	logic [7:0] vsync_delay_low_q; // Vertical sync input delay, low byte
	logic [7:0] timing_polarity_q; // Timing generator polarity control
	logic [7:0] copy_header_q; // Copy-management enable and header
	logic [7:0] copy_payload_high_q; // Copy-management payload, high part
	logic [7:0] copy_payload_low_q; // Copy-management payload, low part
	logic func_run; // Functional logic may advance
	logic bars_active; // Colour bar generator owns the video path
	logic [11:0] h_cnt_q; // Master horizontal position
	logic [11:0] v_cnt_q; // Master vertical position
	logic [11:0] bar_px_q; // Pixels into the current bar
	logic [2:0] bar_idx_q; // Current bar number
	logic h_active, v_active; // Inside the active window
	logic h_sync, v_sync; // Sync intervals, active high
	logic [9:0] bar_r, bar_g, bar_b; // Colour of the current bar

	////////////////////////////////////////////////////////////////////////////////
	// Serial management port; it runs on clk_en alone so power-down and soft reset
	// never lock software out
	serial_mgmt_port #(
		.DEV_ADDR(DEV_ADDR)
	) u_port (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clk_en(clk_en),
		.scl(scl),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.reg_write(reg_write)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Chip control register: soft reset reads one after power-up, the rest zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			chip_control_q <= `RST_CHIP_CONTROL;
		end else if (clk_en) begin
			if (reg_write.wr && reg_write.addr == `SUB_CHIP_CONTROL) begin
				chip_control_q <= reg_write.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timing and copy-management storage; soft reset leaves all of it untouched
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vsync_delay_low_q <= `RST_ZERO_BYTE;
			timing_polarity_q <= `RST_ZERO_BYTE;
			copy_header_q <= `RST_ZERO_BYTE;
			copy_payload_high_q <= `RST_ZERO_BYTE;
			copy_payload_low_q <= `RST_ZERO_BYTE;
		end else if (clk_en && reg_write.wr) begin
			case (reg_write.addr)
				`SUB_VSYNC_DELAY_LOW: vsync_delay_low_q <= reg_write.wdata;
				`SUB_TIMING_POLARITY: timing_polarity_q <= reg_write.wdata;
				// Reserved bits are dropped so they always read zero
				`SUB_COPY_HEADER: copy_header_q <= reg_write.wdata & `MASK_COPY_HEADER;
				`SUB_COPY_PAYLOAD_HIGH: begin
					copy_payload_high_q <= reg_write.wdata & `MASK_COPY_PAYLOAD_HIGH;
				end
				`SUB_COPY_PAYLOAD_LOW: copy_payload_low_q <= reg_write.wdata;
				default: begin
					// Read-only and unmapped sub-addresses ignore writes
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped sub-addresses answer zero
	always_comb begin
		case (rd_addr)
			`SUB_DEVICE_VERSION: rd_data = VERSION_CODE;
			`SUB_CHIP_CONTROL: rd_data = chip_control_q;
			`SUB_VSYNC_DELAY_LOW: rd_data = vsync_delay_low_q;
			`SUB_PIXEL_COUNT_HIGH: rd_data = measure.pixel_count[15:8];
			`SUB_PIXEL_COUNT_LOW: rd_data = measure.pixel_count[7:0];
			`SUB_LINE_COUNT_HIGH_FORMAT: begin
				rd_data = {measure.input_format, 4'h0, measure.line_count[10:8]};
			end
			`SUB_LINE_COUNT_LOW: rd_data = measure.line_count[7:0];
			`SUB_TIMING_POLARITY: rd_data = timing_polarity_q;
			`SUB_COPY_HEADER: rd_data = copy_header_q;
			`SUB_COPY_PAYLOAD_HIGH: rd_data = copy_payload_high_q;
			`SUB_COPY_PAYLOAD_LOW: rd_data = copy_payload_low_q;
			`SUB_PPL_LOW: rd_data = measure.pixels_per_line[7:0];
			`SUB_PPL_HIGH: rd_data = measure.pixels_per_line[15:8];
			`SUB_LPF_LOW: rd_data = measure.lines_per_frame[7:0];
			`SUB_LPF_HIGH: rd_data = measure.lines_per_frame[15:8];
			default: rd_data = `RST_ZERO_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock scheme steering, registered so the clock generator sees clean levels.
	// Direct mode wins over the bypass bit: both feed the pin through, but only
	// direct mode also withdraws 2x interpolation.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clock_cfg <= '0;
		end else if (clk_en) begin
			clock_cfg.direct_mode <= chip_control_q[`CTL_DIRECT_CLOCK];
			clock_cfg.interp_2x_allowed <= !chip_control_q[`CTL_DIRECT_CLOCK];
			clock_cfg.dll_enable <= !chip_control_q[`CTL_DIRECT_CLOCK]
				&& !chip_control_q[`CTL_DLL_BYPASS];
			clock_cfg.pin_is_2x_clock <= chip_control_q[`CTL_DIRECT_CLOCK]
				|| chip_control_q[`CTL_DLL_BYPASS];
			clock_cfg.dll_low_range <= chip_control_q[`CTL_LOW_RANGE];
			// Half-rate stays available in every clock mode
			clock_cfg.half_rate_enable <= half_rate_request;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power, reset and mode levels
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dac_power_down <= 1'b0;
			logic_power_down <= 1'b0;
			func_reset_n <= 1'b0;
			master_active <= 1'b0;
			sync_from_embedded <= 1'b0;
		end else if (clk_en) begin
			dac_power_down <= chip_control_q[`CTL_DAC_POWER_DOWN];
			logic_power_down <= chip_control_q[`CTL_CHIP_POWER_DOWN];
			func_reset_n <= chip_control_q[`CTL_SOFT_RESET_N];
			// Master needs PC-graphics timing; otherwise the device stays slave
			master_active <= chip_control_q[`CTL_MASTER_SELECT] && pc_graphics_mode;
			sync_from_embedded <= timing_polarity_q[`POL_EMBEDDED_TIMING];
		end
	end

	// Functional logic halts under chip power-down and is held under soft reset
	assign func_run = clk_en && !chip_control_q[`CTL_CHIP_POWER_DOWN];
	assign bars_active = chip_control_q[`CTL_COLOUR_BARS] && master_active;

	////////////////////////////////////////////////////////////////////////////////
	// Master raster counters; cleared while the soft reset bit is low or in slave mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			h_cnt_q <= 12'h000;
			v_cnt_q <= 12'h000;
		end else if (func_run) begin
			if (!chip_control_q[`CTL_SOFT_RESET_N] || !master_active) begin
				h_cnt_q <= 12'h000;
				v_cnt_q <= 12'h000;
			end else if (h_cnt_q == 12'(H_TOTAL - 1)) begin
				h_cnt_q <= 12'h000;
				v_cnt_q <= (v_cnt_q == 12'(V_TOTAL - 1)) ? 12'h000 : v_cnt_q + 12'h001;
			end else begin
				h_cnt_q <= h_cnt_q + 12'h001;
			end
		end
	end

	assign h_active = h_cnt_q < 12'(H_ACTIVE);
	assign v_active = v_cnt_q < 12'(V_ACTIVE);
	assign h_sync = h_cnt_q >= 12'(H_SYNC_START) && h_cnt_q < 12'(H_SYNC_END);
	assign v_sync = v_cnt_q >= 12'(V_SYNC_START) && v_cnt_q < 12'(V_SYNC_END);

	////////////////////////////////////////////////////////////////////////////////
	// Timing toward the external memory; silent in slave mode, where sync comes in
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hsync_out <= 1'b0;
			vsync_out <= 1'b0;
			data_request <= 1'b0;
		end else if (func_run) begin
			if (master_active && chip_control_q[`CTL_SOFT_RESET_N]) begin
				// Polarity bit set means active high sync out
				hsync_out <= !(h_sync ^ timing_polarity_q[`POL_HSYNC_OUT]);
				vsync_out <= !(v_sync ^ timing_polarity_q[`POL_VSYNC_OUT]);
				// No request while bars run: the source is ignored anyway
				data_request <= h_active && v_active && !bars_active;
			end else begin
				hsync_out <= 1'b0;
				vsync_out <= 1'b0;
				data_request <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bar position: a pixel counter per bar avoids a divider in the pixel path
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bar_px_q <= 12'h000;
			bar_idx_q <= 3'h0;
		end else if (func_run) begin
			if (!h_active || !chip_control_q[`CTL_SOFT_RESET_N]) begin
				bar_px_q <= 12'h000;
				bar_idx_q <= 3'h0;
			end else if (bar_px_q == 12'(BAR_WIDTH - 1)) begin
				bar_px_q <= 12'h000;
				bar_idx_q <= bar_idx_q + 3'h1;
			end else begin
				bar_px_q <= bar_px_q + 12'h001;
			end
		end
	end

	// Bars run white, yellow, cyan, green, magenta, red, blue, black
	always_comb begin
		bar_g = bar_idx_q[2] ? `BAR_LEVEL_LOW : `BAR_LEVEL_HIGH;
		bar_r = bar_idx_q[1] ? `BAR_LEVEL_LOW : `BAR_LEVEL_HIGH;
		bar_b = bar_idx_q[0] ? `BAR_LEVEL_LOW : `BAR_LEVEL_HIGH;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Video path: bars replace the inputs, blanked outside the active window; plain inputs pass whole
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			video_out <= '0;
		end else if (func_run) begin
			if (!chip_control_q[`CTL_SOFT_RESET_N]) begin
				video_out <= '0;
			end else if (bars_active) begin
				if (h_active && v_active) begin
					video_out <= '{ch_r: bar_r, ch_g: bar_g, ch_b: bar_b};
				end else begin
					video_out <= '0;
				end
			end else begin
				video_out <= video_in;
			end
		end
	end

endmodule

`default_nettype wire

// file: tb/sysctl_partner.sv
// Far side: pulled-up open-drain data wire and a pixel source.
// Assumes the host side sets host_sda high to release the wire.
`timescale 1ns/10ps
`default_nettype none
module sysctl_partner (
	input wire logic clk_sys,
	input wire logic host_sda,
	input wire logic sda_oe_n,
	output logic sda_wire,
	output sysctl_pkg::pixel_type video_in
);
	import sysctl_pkg::*;
	// Pull-up wins unless a party pulls low
	assign sda_wire = host_sda & sda_oe_n;
	// New pixel every cycle, so a stale pixel never passes for a fresh one
	initial video_in = 30'h0000_0001;
	always @(posedge clk_sys) begin
		video_in <= video_in + 30'h0000_1001;
	end
endmodule
`default_nettype wire

// file: tb/sysctl_props.sv
// Checker on the ports of the system control bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sysctl_props (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic scl,
	input wire logic pc_graphics_mode,
	input wire logic half_rate_request,
	input wire sysctl_pkg::pixel_type video_in,
	input wire sysctl_pkg::pixel_type video_out,
	input wire sysctl_pkg::clock_cfg_type clock_cfg,
	input wire logic sda_oe_n,
	input wire logic logic_power_down,
	input wire logic func_reset_n,
	input wire logic master_active,
	input wire logic hsync_out,
	input wire logic vsync_out,
	input wire logic data_request
);
	import sysctl_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Plain pass-through state; outputs lag the control bits by a cycle
	// A low clock enable freezes the path, so it counts as not running
	wire run = clk_en && func_reset_n && !logic_power_down && !master_active;
	////////////////////////////////////////////////////////////////////////////////
	pass_through_a: assert property (run && $past(run) |-> video_out == $past(video_in))
		else $error("video not passed through");
	power_freeze_a: assert property (logic_power_down && $past(logic_power_down)
		|-> $stable(video_out) && $stable(hsync_out) && $stable(data_request))
		else $error("logic ran while powered down");
	soft_hold_a: assert property (!func_reset_n && !$past(func_reset_n)
		|-> video_out == '0 && !data_request)
		else $error("functions ran in soft reset");
	direct_clock_a: assert property (clock_cfg.direct_mode |-> clock_cfg.pin_is_2x_clock
		&& !clock_cfg.dll_enable && !clock_cfg.interp_2x_allowed)
		else $error("direct mode clocking wrong");
	loop_used_a: assert property (func_reset_n && $past(func_reset_n) && !clock_cfg.direct_mode
		&& !clock_cfg.pin_is_2x_clock |-> clock_cfg.dll_enable)
		else $error("loop not used");
	half_rate_a: assert property (clock_cfg.direct_mode && $past(clock_cfg.direct_mode)
		&& $past(half_rate_request, 2) == $past(half_rate_request)
		|-> clock_cfg.half_rate_enable == $past(half_rate_request))
		else $error("half rate clock wrong");
	slave_quiet_a: assert property (!master_active && !$past(master_active)
		|-> !hsync_out && !vsync_out && !data_request)
		else $error("timing driven as slave");
	master_pc_a: assert property (master_active |-> $past(pc_graphics_mode))
		else $error("master outside pc mode");
	sda_low_scl_a: assert property ($changed(sda_oe_n) |-> !scl)
		else $error("data wire moved with scl high");
	// Main scenarios
	cover property (data_request);
	cover property (logic_power_down);
	cover property (clock_cfg.direct_mode && clock_cfg.half_rate_enable);
endmodule
bind system_control_regs sysctl_props props_u (.*);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the system control bank.
// Assumes the partner resolves the data wire and feeds pixels.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sysctl_pkg::*;
	localparam logic [7:0] VER = 8'h3c; // Arbitrary value
	logic clk_sys = 0, nrst = 0, scl = 1, hsda = 1;
	logic pc_graphics_mode = 0, half_rate_request = 0, clk_en = 1;
	measure_type measure; // Readback values from the measuring side
	logic sda_wire, sda_out, sda_oe_n, dac_power_down, logic_power_down, func_reset_n;
	logic master_active, sync_from_embedded, hsync_out, vsync_out, data_request;
	pixel_type video_in, video_out;
	clock_cfg_type clock_cfg;
	logic [7:0] v;
	int num_errors = 0, cmp_count = 0;
	// Short raster keeps frames at 128 cycles
	system_control_regs #(.VERSION_CODE(VER), .H_ACTIVE(8), .H_SYNC_START(10),
		.H_SYNC_END(12), .H_TOTAL(16), .V_ACTIVE(4), .V_SYNC_START(5), .V_SYNC_END(6),
		.V_TOTAL(8)) dut_u (.sda_in(sda_wire), .*);
	sysctl_partner far_u (.clk_sys(clk_sys), .host_sda(hsda), .sda_oe_n(sda_oe_n),
		.sda_wire(sda_wire), .video_in(video_in));
	initial forever #2 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One wire phase, three clocks long so the port samples it three times
	task automatic st(input logic s, input logic d);
		@(posedge clk_sys);
		scl <= s;
		hsda <= d;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic tx(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			st(0, b[i]);
			st(1, b[i]);
			st(0, b[i]);
		end
		st(0, 1);
		st(1, 1);
	endtask
	task automatic sta();
		st(0, 1);
		st(1, 1);
		st(1, 0);
		st(0, 0);
	endtask
	task automatic sto();
		st(0, 0);
		st(1, 0);
		st(1, 1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sta();
		tx(8'h40);
		tx(a);
		tx(d);
		sto();
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sta();
		tx(8'h40);
		tx(a);
		sta();
		tx(8'h41);
		for (int i = 7; i >= 0; i--) begin
			st(0, 1);
			st(1, 1);
			d[i] = sda_wire;
		end
		st(0, 1);
		st(1, 1);
		sto();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({sda_out, dac_power_down, logic_power_down, func_reset_n, master_active}, 2);
		rd(8'h03, v);
		chk(v, 8'h01);
		wr(8'h02, 8'hff);
		rd(8'h02, v);
		chk(v, VER);
	endtask
	task automatic t_clock();
		logic [7:0] cw [4] = '{8'h81, 8'h41, 8'h01, 8'h11};
		// Pin as 2x, direct, low range, loop on, 2x interpolation allowed
		logic [4:0] ex [4] = '{5'b11000, 5'b10001, 5'b00011, 5'b00111};
		for (int i = 0; i < 4; i++) begin
			wr(8'h03, cw[i]);
			chk({clock_cfg.pin_is_2x_clock, clock_cfg.direct_mode, clock_cfg.dll_low_range,
				clock_cfg.dll_enable, clock_cfg.interp_2x_allowed}, ex[i]);
		end
		wr(8'h03, 8'h81);
		half_rate_request <= 1;
		repeat (4) @(posedge clk_sys);
		chk(clock_cfg.half_rate_enable, 1);
		half_rate_request <= 0;
		wr(8'h03, 8'h01);
	endtask
	task automatic t_power();
		logic [7:0] ma [5] = '{8'h7f, 8'h80, 8'h7e, 8'h86, 8'h89};
		logic [7:0] me [5] = '{8'h85, 8'ha6, 8'hcd, 8'h57, 8'h24};
		wr(8'h03, 8'h09);
		chk(dac_power_down, 1);
		wr(8'h03, 8'h05);
		chk(logic_power_down, 1);
		rd(8'h03, v);
		chk(v, 8'h05);
		// Measurement bytes stay readable while the logic sleeps
		for (int i = 0; i < 5; i++) begin
			rd(ma[i], v);
			chk(v, me[i]);
		end
		wr(8'h03, 8'h01);
		chk({dac_power_down, logic_power_down}, 0);
		// Frozen clock enable: a whole write goes unseen
		clk_en <= 0;
		wr(8'h03, 8'h09);
		clk_en <= 1;
		rd(8'h03, v);
		chk({dac_power_down, v}, 9'h001);
	endtask
	task automatic t_soft();
		wr(8'h7c, 8'h5c);
		wr(8'h03, 8'h00);
		chk({func_reset_n, video_out}, 0);
		rd(8'h7c, v);
		chk(v, 8'h5c);
		wr(8'h03, 8'h01);
		chk(func_reset_n, 1);
	endtask
	task automatic t_master();
		int n, nh, nv;
		wr(8'h82, 8'h20);
		chk(sync_from_embedded, 1);
		wr(8'h03, 8'h03);
		chk(master_active, 0);
		pc_graphics_mode <= 1;
		n = 0;
		repeat (200) begin
			@(posedge clk_sys);
			n += (data_request === 1'b1);
		end
		chk({master_active, n != 0}, 3);
		wr(8'h03, 8'h23);
		n = 0;
		nh = 0;
		nv = 0;
		// One whole frame; polarity bits clear give low sync pulses:
		// two pixels on each of eight lines, and one line of sixteen pixels
		repeat (128) begin
			@(posedge clk_sys);
			n += (video_out === 30'h3fff_ffff);
			nh += (hsync_out === 1'b0);
			nv += (vsync_out === 1'b0);
		end
		chk(n != 0, 1);
		chk(nh, 16);
		chk(nv, 16);
		pc_graphics_mode <= 0;
		repeat (3) @(posedge clk_sys);
		chk(master_active, 0);
		wr(8'h03, 8'h01);
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Run needs some 33 us; cut off well beyond
	initial begin
		#200000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		measure <= '{pixel_count: 16'habcd, input_format: 1'b1, line_count: 11'h5a6,
			pixels_per_line: 16'h1357, lines_per_frame: 16'h2468};
		nrst <= 1;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_clock();
		t_power();
		t_soft();
		t_master();
		final_report();
	end
endmodule
`default_nettype wire
